/* drtc_pkg.sv */
// Package: constants, carriers and helpers for the dual reload timer
package drtc_pkg;

  // Counter width and values after reset
  localparam int unsigned DRTC_CNT_W = 8;
  localparam logic [7:0] DRTC_CNT_RST = 8'h00;
  localparam logic [7:0] DRTC_PRE_RST = 8'h00;
  localparam logic [7:0] DRTC_CNT_MAX = 8'hff;
  localparam logic [7:0] DRTC_CLR_VAL = 8'h00;

  // Prescaler width and divide masks (divide by 8, 64, 65536)
  localparam int unsigned DRTC_DIV_W = 16;
  localparam logic [15:0] DRTC_DIV_RST = 16'h0000;
  localparam logic [15:0] DRTC_DIV_ONE = 16'h0001;
  localparam logic [15:0] DRTC_DIV8_MASK = 16'h0007;
  localparam logic [15:0] DRTC_DIV64_MASK = 16'h003f;
  localparam logic [15:0] DRTC_DIV65536_MASK = 16'hffff;

  // Clock source of the first reload timer
  typedef enum logic [1:0] {
    DRTC_A_CPU,
    DRTC_A_DIV8,
    DRTC_A_DIV64,
    DRTC_A_BOVF
  } drtc_a_src_t;

  // Clock source of the second timer or counter
  typedef enum logic [2:0] {
    DRTC_B_CPU,
    DRTC_B_DIV65536,
    DRTC_B_EXT,
    DRTC_B_LOW,
    DRTC_B_HIGH
  } drtc_b_src_t;

  // Static configuration bits
  typedef struct packed {
    drtc_a_src_t a_src;
    drtc_b_src_t b_src;
    logic b_cnt_mode;
    logic cascade;
    logic a_int_en;
    logic b_int_en;
  } drtc_cfg_t;

  // One write strobe with its data byte
  typedef struct packed {
    logic we;
    logic [7:0] data;
  } drtc_wr_t;

  // Whole state of the block
  typedef struct packed {
    logic [7:0] a_cnt;
    logic [7:0] b_cnt;
    logic [7:0] a_pre;
    logic [7:0] b_pre;
    logic [15:0] div;
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    logic ext_lvl;
    logic a_irq;
    logic b_irq;
  } drtc_state_t;

  // Count up by one on tick; reload preset on wrap, carry in bit 8
  function automatic logic [8:0] drtc_step(input logic [7:0] cnt,
                                           input logic [7:0] pre,
                                           input logic tick);
    logic [8:0] res;
    res = {1'h0, cnt};
    if (tick) begin
      if (cnt == DRTC_CNT_MAX) begin
        res = {1'h1, pre};
      end else begin
        res = {1'h0, cnt + 8'h01};
      end
    end
    return res;
  endfunction

endpackage

/* drtc_top.sv */
// Dual 8-bit reload timer/counter with cascade and prescaler
// Operation
// - Two 8-bit units; second may count events
// - Units cascade into one 16-bit counter
// - Count up; on wrap reload preset
// - Overflow raises enabled interrupt with reload
// - Writing zero clears second in counter mode
// - Count readable any time, read is harmless
// - First clock: CPU, /8, /64, second overflow
// - Second clock: CPU, /65536, external, low, high
module drtc_top
  import drtc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire drtc_cfg_t cfg,
  input wire drtc_wr_t a_wr,
  input wire drtc_wr_t b_wr,
  input wire logic external_count_input,
  output logic [7:0] first_reload_timer,
  output logic [7:0] second_timer_or_counter,
  output logic a_irq,
  output logic b_irq
);

  drtc_state_t st_ff; // Registered state
  drtc_state_t nxt_st; // Next state
  logic tick_a; // First unit count enable
  logic tick_b; // Second unit count enable
  logic ext_rise; // Filtered rising edge of external input
  logic a_ovf; // First unit wrap
  logic b_ovf; // Second unit wrap
  logic b_clear; // Zero write in counter mode
  logic [8:0] a_res; // Step result, first unit
  logic [8:0] b_res; // Step result, second unit

  // Divided source strobe: every masked prescaler bit is set
  function automatic logic drtc_div_hit(input logic [15:0] div,
                                        input logic [15:0] mask);
    return (div & mask) == mask;
  endfunction

  // Next-state logic for prescaler, sync, both units and interrupts
  always_comb begin
    nxt_st = st_ff;
    // Free-running prescaler shared by all divided sources
    nxt_st.div = st_ff.div + DRTC_DIV_ONE;
    // Three-stage sync; only stages two and three are compared
    nxt_st.ext_s1 = external_count_input;
    nxt_st.ext_s2 = st_ff.ext_s1;
    nxt_st.ext_s3 = st_ff.ext_s2;
    ext_rise = 1'h0;
    // A one-sample glitch never makes stages two and three agree,
    // so it is dropped rather than counted
    if (st_ff.ext_s2 == st_ff.ext_s3) begin
      nxt_st.ext_lvl = st_ff.ext_s2;
      ext_rise = st_ff.ext_s2 & ~st_ff.ext_lvl;
    end
    // Second unit source select
    case (cfg.b_src)
      // Every cycle
      DRTC_B_CPU: tick_b = 1'h1;
      // Once per full prescaler turn
      DRTC_B_DIV65536: begin
        tick_b = drtc_div_hit(st_ff.div, DRTC_DIV65536_MASK);
      end
      // Filtered pin edge
      DRTC_B_EXT: tick_b = ext_rise;
      // Constant levels never produce an edge
      default: tick_b = 1'h0;
    endcase
    b_res = drtc_step(st_ff.b_cnt, st_ff.b_pre, tick_b);
    b_ovf = b_res[8];
    // First unit source; cascade forces the second unit's carry
    if (cfg.cascade) begin
      // High byte of the 16-bit pair
      tick_a = b_ovf;
    end else begin
      case (cfg.a_src)
        // Every cycle
        DRTC_A_CPU: tick_a = 1'h1;
        // Every eighth cycle
        DRTC_A_DIV8: begin
          tick_a = drtc_div_hit(st_ff.div, DRTC_DIV8_MASK);
        end
        // Every sixty-fourth cycle
        DRTC_A_DIV64: begin
          tick_a = drtc_div_hit(st_ff.div, DRTC_DIV64_MASK);
        end
        // Second unit overflow without the 16-bit view
        default: tick_a = b_ovf;
      endcase
    end
    a_res = drtc_step(st_ff.a_cnt, st_ff.a_pre, tick_a);
    a_ovf = a_res[8];
    nxt_st.a_cnt = a_res[7:0];
    nxt_st.b_cnt = b_res[7:0];
    // Presets only feed the reload path, never the live count
    if (a_wr.we) begin
      // Takes effect at the next wrap
      nxt_st.a_pre = a_wr.data;
    end
    // Zero clear only exists while the second unit counts events
    b_clear = b_wr.we && cfg.b_cnt_mode && (b_wr.data == DRTC_CLR_VAL);
    if (b_wr.we) begin
      // A clear also leaves zero as the reload value
      nxt_st.b_pre = b_wr.data;
    end
    // Clear beats a same-cycle count so software sees zero
    if (b_clear) begin
      nxt_st.b_cnt = DRTC_CLR_VAL;
    end
    // Interrupt pulse lands in the cycle the reload shows
    nxt_st.a_irq = a_ovf & cfg.a_int_en;
    nxt_st.b_irq = b_ovf & cfg.b_int_en;
  end

  // State register; reset loads constants only
  // Idle pin is low, so the cleared level makes no false edge
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '{a_cnt: DRTC_CNT_RST, b_cnt: DRTC_CNT_RST,
                 a_pre: DRTC_PRE_RST, b_pre: DRTC_PRE_RST,
                 div: DRTC_DIV_RST, ext_s1: 1'h0, ext_s2: 1'h0,
                 ext_s3: 1'h0, ext_lvl: 1'h0, a_irq: 1'h0,
                 b_irq: 1'h0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Counts are plain flop outputs, so reading them has no side effect
  assign first_reload_timer = st_ff.a_cnt;
  assign second_timer_or_counter = st_ff.b_cnt;
  assign a_irq = st_ff.a_irq;
  assign b_irq = st_ff.b_irq;

  // Checks on the block's outputs and internal state
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // Wrap shows the preset held one cycle earlier
  a_a_reload_preset: assert property (
    (tick_a && st_ff.a_cnt == DRTC_CNT_MAX)
      |=> first_reload_timer == $past(st_ff.a_pre))
    else $error("first unit did not reload its preset");

  // Interrupt only ever rides on an enabled reload
  a_irq_with_reload: assert property (
    a_irq |-> $past(cfg.a_int_en) && $past(st_ff.a_cnt) == DRTC_CNT_MAX
      && first_reload_timer == $past(st_ff.a_pre))
    else $error("first interrupt without enabled reload");

  // Enabled second overflow always pulses its interrupt
  a_b_irq_gate: assert property (
    (tick_b && st_ff.b_cnt == DRTC_CNT_MAX && cfg.b_int_en) |=> b_irq)
    else $error("second interrupt missing on overflow");

  // Zero write in counter mode empties the count at once
  a_b_zero_clear: assert property (
    (b_wr.we && cfg.b_cnt_mode && b_wr.data == DRTC_CLR_VAL)
      |=> second_timer_or_counter == DRTC_CLR_VAL)
    else $error("zero write did not clear the counter");

  // Count moves only on a tick, so idle reads are harmless
  a_a_hold_idle: assert property (
    !tick_a |=> $stable(first_reload_timer))
    else $error("first count moved without a tick");

  // Divide-by-eight source leaves seven quiet cycles between ticks
  a_div8_spacing: assert property (
    (!cfg.cascade && cfg.a_src == DRTC_A_DIV8 && tick_a)
      |=> !tick_a [*7])
    else $error("divide by eight ticked too early");

  // Constant source selections never count
  a_b_const_idle: assert property (
    (cfg.b_src inside {DRTC_B_LOW, DRTC_B_HIGH} && !b_wr.we)
      |=> $stable(second_timer_or_counter))
    else $error("second unit counted on a constant level");

  // An agreed rising pin level adds exactly one to the count unless it wraps or a write lands
  a_ext_edge_count: assert property (
    ($past(cfg.b_src) == DRTC_B_EXT && $rose(st_ff.ext_lvl)
      && !$past(b_wr.we) && $past(st_ff.b_cnt) != DRTC_CNT_MAX)
      |-> second_timer_or_counter == $past(st_ff.b_cnt) + 8'h01)
    else $error("external edge not counted");

  // Low byte carry advances the high byte by one
  a_cascade_carry: assert property (
    (cfg.cascade && tick_b && st_ff.b_cnt == DRTC_CNT_MAX
      && st_ff.a_cnt != DRTC_CNT_MAX)
      |=> first_reload_timer == $past(st_ff.a_cnt) + 8'h01)
    else $error("cascade carry did not advance high byte");

  // New preset waits for the wrap; live count untouched
  a_preset_no_disturb: assert property (
    (a_wr.we && !tick_a) |=> $stable(first_reload_timer))
    else $error("preset write disturbed the count");

  // Second unit wrap shows its preset unless a clear wins
  a_b_reload_preset: assert property (
    (tick_b && st_ff.b_cnt == DRTC_CNT_MAX && !b_clear)
      |=> second_timer_or_counter == $past(st_ff.b_pre))
    else $error("second unit did not reload its preset");

  // Masked overflow still reloads but stays silent
  a_a_irq_masked: assert property (
    (a_ovf && !cfg.a_int_en) |=> !a_irq)
    else $error("masked overflow raised an interrupt");

  // Filtered level only follows two agreeing sync stages
  a_sync_agree: assert property (
    $changed(st_ff.ext_lvl)
      |-> $past(st_ff.ext_s2) == $past(st_ff.ext_s3)
        && st_ff.ext_lvl == $past(st_ff.ext_s2))
    else $error("pin level taken before the sync stages agreed");

  // Main scenarios the bench should reach
  c_a_overflow: cover property (tick_a && st_ff.a_cnt == DRTC_CNT_MAX);
  c_cascade_wrap: cover property (cfg.cascade && a_irq);
  c_ext_count: cover property (cfg.b_src == DRTC_B_EXT && ext_rise);
  c_b_clear: cover property (b_clear && st_ff.b_cnt != DRTC_CLR_VAL);
  c_b_slow_tick: cover property (cfg.b_src == DRTC_B_DIV65536 && tick_b);

endmodule

/* tb_top.sv */
// Bench for the dual reload timer: sources, reloads, clears, cascade
`define CHK(nm, e, g) \
  if ((g) !== (e)) begin \
    $display("wrong value %s exp %h got %h", nm, e, g); \
    n_mismatch++; \
  end \
  num_checks++;
module tb_top
  import drtc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'h0; // 100 MHz
  logic rst = 1'h1; // Held for 20 cycles
  drtc_cfg_t cfg; // Static configuration
  drtc_wr_t a_wr; // First preset write
  drtc_wr_t b_wr; // Second preset write
  logic ext_in; // Event pin
  logic [7:0] cnt_a;
  logic [7:0] cnt_b;
  logic irq_a;
  logic irq_b;
  int n_mismatch = 0;
  int num_checks = 0;
  int n; // Cycles between overflows
  logic [7:0] v; // Snapshot of a count
  // Source table: preset chosen so a period stays short
  drtc_a_src_t srcs[4] = '{DRTC_A_CPU, DRTC_A_DIV8, DRTC_A_DIV64,
                           DRTC_A_BOVF};
  logic [7:0] pres[4] = '{8'hf0, 8'hf8, 8'hfe, 8'hfe};
  int per[4] = '{16, 64, 128, 512};

  drtc_top dut (
    .sys_clk(sys_clk),
    .rst(rst),
    .cfg(cfg),
    .a_wr(a_wr),
    .b_wr(b_wr),
    .external_count_input(ext_in),
    .first_reload_timer(cnt_a),
    .second_timer_or_counter(cnt_b),
    .a_irq(irq_a),
    .b_irq(irq_b)
  );

  // Free running clock
  always #5 sys_clk = ~sys_clk;

  // Let k edges pass, then settle just after the last one
  task automatic step(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask

  // One-cycle preset write strobe
  task automatic wr(input bit sel, input logic [7:0] d);
    if (sel) b_wr = '{1'h1, d};
    else a_wr = '{1'h1, d};
    step(1);
    a_wr = '0;
    b_wr = '0;
  endtask

  // Count cycles up to an irq pulse; bounded so a silent unit returns
  task automatic wt(input bit sel, output int k);
    k = 0;
    do begin
      step(1);
      k++;
    end while ((sel ? irq_b : irq_a) !== 1'h1 && k < 1100);
  endtask

  // Verdict and end of run
  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Main sequence
  initial begin
    cfg = '0;
    cfg.b_src = DRTC_B_LOW; // Nothing ticks during and after reset
    cfg.a_src = DRTC_A_BOVF;
    a_wr = '0;
    b_wr = '0;
    ext_in = 1'h0;
    step(20);
    rst = 1'h0;
    step(20);
    `CHK("a idle", 8'h00, cnt_a)
    `CHK("b low", 8'h00, cnt_b)
    cfg.b_src = DRTC_B_CPU; // B wraps every 256 for the overflow source
    cfg.a_int_en = 1'h1;
    // Second period is whole; the first may start mid-count
    for (int i = 0; i < 4; i++) begin
      wr(0, pres[i]);
      cfg.a_src = srcs[i];
      wt(0, n);
      wt(0, n);
      `CHK("a period", per[i], n)
      `CHK("a reload", pres[i], cnt_a)
    end
    // Preset f0 so the hold and wrap figures below are known
    wr(0, 8'hf0);
    cfg.a_src = DRTC_A_CPU;
    wt(0, n);
    wr(0, 8'he0); // New preset must wait for next wrap
    `CHK("a hold", 8'hf1, cnt_a)
    wt(0, n);
    `CHK("a to wrap", 15, n)
    `CHK("a new pre", 8'he0, cnt_a)
    cfg.a_int_en = 1'h0;
    wt(0, n);
    `CHK("a masked", 1100, n)
    cfg.b_int_en = 1'h1;
    wr(1, 8'hf0);
    wt(1, n);
    wt(1, n);
    `CHK("b period", 16, n)
    `CHK("b reload", 8'hf0, cnt_b)
    cfg.b_src = DRTC_B_HIGH;
    v = cnt_b;
    step(50);
    `CHK("b high", v, cnt_b)
    cfg.b_cnt_mode = 1'h1;
    cfg.b_src = DRTC_B_EXT;
    wr(1, 8'h00);
    `CHK("b clear", 8'h00, cnt_b)
    repeat (3) begin
      ext_in = 1'h1;
      step(6);
      ext_in = 1'h0;
      step(6);
    end
    `CHK("b events", 8'h03, cnt_b)
    step(20);
    `CHK("b read", 8'h03, cnt_b)
    // Cascade: a_src left at a fast source, cascade must override it
    wr(0, 8'h00);
    cfg.b_cnt_mode = 1'h0;
    cfg.b_src = DRTC_B_CPU;
    cfg.cascade = 1'h1;
    wt(1, n);
    v = cnt_a;
    wt(1, n);
    `CHK("low byte", 256, n)
    `CHK("high byte", v + 8'h01, cnt_a)
    // Slowest source: one step when the prescaler turns over, then quiet
    cfg.cascade = 1'h0;
    cfg.b_src = DRTC_B_DIV65536;
    v = cnt_b;
    n = 0;
    while (cnt_b === v && n < 65540) begin
      step(1);
      n++;
    end
    `CHK("b slow tick", v + 8'h01, cnt_b)
    step(100);
    `CHK("b slow hold", v + 8'h01, cnt_b)
    end_sim;
  end

  // Watchdog past the roughly 66000 cycles of the sequence, most of
  // them spent waiting for one full prescaler turn
  initial begin
    #800000;
    n_mismatch++;
    end_sim;
  end
endmodule
